/* rtl/dsst_params.svh */
// constants for the drive status and trip block
// Operation
// - status word always readable, any command source
// - bits 0,3,4: ready, faulted, supply present
// - bits 1,2,6 follow sequencer states
// - bit 5 low during quick-stop reaction
// - bit 9 set when fieldbus controls
// - bit 12 set for jog reference
// - bit 13 set for reverse direction
// - bit 14 set for fieldbus reference
// - bit 15 set when stopping or quick-stop
// - any trip disables power stage immediately
// - trips stay latched until reset
// - re-enable blocked while any trip latched
// - reset clears only trips whose cause ended
// - report trip by code 1 to 7
// - warnings shown only when display enabled
// - overvoltage warning at trip/brake midpoint
// - undervoltage warning at min/trip midpoint
// - overcurrent warn at 2, trip at 5
// - volts-per-hertz: 200 percent for 1 s trips
// - stall trip after stall time, warn half
// - inverse-time trip over allowance, warn half
// - stack overcurrent trips at once, no warning
`ifndef DSST_PARAMS_SVH
`define DSST_PARAMS_SVH
`define DSST_CLK_PERIOD_PS 4000
`define DSST_TICK_TIME_NS 1000000
`define DSST_CLIM_TIME_MS 1000
`define DSST_STALL_TIME_S 200
`define DSST_OC_WARN_CNT 2
`define DSST_OC_TRIP_CNT 5
`define DSST_ADR_STATUS 8'h00
`define DSST_ADR_CONFIG 8'h04
`define DSST_ADR_OV_LEVEL 8'h08
`define DSST_ADR_BRAKE_LEVEL 8'h0c
`define DSST_ADR_UV_LEVEL 8'h10
`define DSST_ADR_MIN_LEVEL 8'h14
`define DSST_ADR_STALL_TIME 8'h18
`define DSST_ADR_INV_ALLOW 8'h1c
`define DSST_ADR_TRIPS 8'h20
`define DSST_ADR_WARNINGS 8'h24
`define DSST_ADR_TRIP_CODE 8'h28
`define DSST_CFG_WARN_EN_BIT 0
`define DSST_CFG_VHZ_BIT 1
`define DSST_CFG_RESET 2'h1
`define DSST_OV_LEVEL_RESET 16'hc800
`define DSST_BRAKE_LEVEL_RESET 16'hbb80
`define DSST_UV_LEVEL_RESET 16'h5dc0
`define DSST_MIN_LEVEL_RESET 16'h4e20
`define DSST_INV_ALLOW_RESET 32'h0000ea60
`define DSST_TRIP_OV 1
`define DSST_TRIP_STACK_OC 2
`define DSST_TRIP_UV 3
`define DSST_TRIP_OC 4
`define DSST_TRIP_CLIM 5
`define DSST_TRIP_STALL 6
`define DSST_TRIP_INV 7
`endif

/* rtl/dsst_pkg.sv */
// types of the drive status and trip block
package dsst_pkg;
  typedef enum logic [2:0] {
    DSST_NOT_READY,
    DSST_SW_ON_DISABLED,
    DSST_READY,
    DSST_SWITCHED_ON,
    DSST_OP_ENABLED,
    DSST_QUICKSTOP,
    DSST_FAULT_REACTION,
    DSST_FAULTED
  } dsst_seq_state_e;
  typedef struct packed {
    logic init_done;
    logic config_mode;
    logic line_present;
    logic quickstop_react;
    logic enable_op_cmd;
    logic comms_ctrl_sel;
    logic jog_sel;
    logic reverse_sel;
    logic comms_ref_sel;
  } dsst_seq_s;
  typedef struct packed {
    logic [15:0] dc_link;
    logic stack_oc;
    logic oc_event;
    logic oc_clear;
    logic over_200;
    logic in_limit;
    logic rotating;
    logic overload;
  } dsst_meas_s;
  typedef struct packed {
    logic [15:0] status;
    logic [7:1] trips;
    logic [7:1] warn;
    logic [5:0] code;
    logic [2:0] oc_cnt;
    logic [31:0] tick_cnt;
    logic [15:0] clim_ms;
    logic [31:0] stall_ms;
    logic [31:0] inv_acc;
    logic rst_cw_q;
    logic [1:0] cfg;
    logic [15:0] ov_lvl;
    logic [15:0] brake_lvl;
    logic [15:0] uv_lvl;
    logic [15:0] min_lvl;
    logic [15:0] stall_s;
    logic [31:0] inv_allow;
    logic ack;
    logic [31:0] rdata;
  } dsst_state_s;
endpackage

/* rtl/dsst_top.sv */
// drive sequencer status word, trip latches and early warnings
`include "dsst_params.svh"
module dsst_top import dsst_pkg::*; #(
  parameter int TICK_CYCLES = `DSST_TICK_TIME_NS * 1000 / `DSST_CLK_PERIOD_PS,
  parameter int CLIM_MS = `DSST_CLIM_TIME_MS,
  parameter logic [15:0] STALL_S_RESET = 16'(`DSST_STALL_TIME_S)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // sequencer side
  input wire dsst_seq_state_e seq_state_i,
  input wire dsst_seq_s seq_i,
  input wire logic fault_reset_cw_i,
  input wire logic run_request_i,
  // measurement comparators
  input wire dsst_meas_s meas_i,
  // outputs
  output logic power_enable_o,
  output logic [15:0] status_word_o,
  output logic [7:1] trips_o,
  output logic [7:1] warnings_o,
  output logic [5:0] trip_code_o
);
  dsst_state_s q, d;

  logic [7:1] src_active;
  logic [7:1] trip_set;
  logic [7:1] warn_raw;
  logic reset_edge;
  logic tick;
  logic [16:0] ov_mid, uv_mid;

  // lowest numbered latched trip is reported first
  function automatic logic [5:0] dsst_code(input logic [7:1] t);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 7; i >= 1; i--) begin
      if (t[i]) begin
        c = 6'(i);
      end
    end
    return c;
  endfunction

  function automatic logic [15:0] dsst_wr16(input logic [15:0] old, input logic [31:0] w,
                                            input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = w[7:0];
    end
    if (s[1]) begin
      r[15:8] = w[15:8];
    end
    return r;
  endfunction

  assign tick = (q.tick_cnt == 32'(TICK_CYCLES - 1));
  assign reset_edge = fault_reset_cw_i & ~q.rst_cw_q;
  assign ov_mid = ({1'b0, q.ov_lvl} + {1'b0, q.brake_lvl}) >> 1;
  assign uv_mid = ({1'b0, q.min_lvl} + {1'b0, q.uv_lvl}) >> 1;

  always_comb begin
    src_active = '0;
    src_active[`DSST_TRIP_OV] = meas_i.dc_link >= q.ov_lvl;
    src_active[`DSST_TRIP_STACK_OC] = meas_i.stack_oc;
    src_active[`DSST_TRIP_UV] = meas_i.dc_link <= q.uv_lvl;
    src_active[`DSST_TRIP_OC] = meas_i.oc_event;
    src_active[`DSST_TRIP_CLIM] = q.cfg[`DSST_CFG_VHZ_BIT] & meas_i.over_200;
    src_active[`DSST_TRIP_STALL] = meas_i.in_limit & ~meas_i.rotating;
    src_active[`DSST_TRIP_INV] = q.inv_acc > q.inv_allow;
  end

  always_comb begin
    trip_set = '0;
    trip_set[`DSST_TRIP_OV] = src_active[`DSST_TRIP_OV];
    trip_set[`DSST_TRIP_STACK_OC] = meas_i.stack_oc;
    trip_set[`DSST_TRIP_UV] = src_active[`DSST_TRIP_UV];
    trip_set[`DSST_TRIP_OC] = meas_i.oc_event &
                              (q.oc_cnt == 3'(`DSST_OC_TRIP_CNT - 1));
    trip_set[`DSST_TRIP_CLIM] = src_active[`DSST_TRIP_CLIM] &
                                (q.clim_ms >= 16'(CLIM_MS));
    trip_set[`DSST_TRIP_STALL] = src_active[`DSST_TRIP_STALL] &
                                 (q.stall_ms > 32'(q.stall_s) * 32'd1000);
    trip_set[`DSST_TRIP_INV] = src_active[`DSST_TRIP_INV];
  end

  // no warning for stack overcurrent or current limit
  always_comb begin
    warn_raw = '0;
    warn_raw[`DSST_TRIP_OV] = {1'b0, meas_i.dc_link} >= ov_mid;
    warn_raw[`DSST_TRIP_UV] = {1'b0, meas_i.dc_link} <= uv_mid;
    warn_raw[`DSST_TRIP_OC] = q.oc_cnt >= 3'(`DSST_OC_WARN_CNT);
    warn_raw[`DSST_TRIP_STALL] = src_active[`DSST_TRIP_STALL] &
                                 (q.stall_ms > 32'(q.stall_s) * 32'd500);
    warn_raw[`DSST_TRIP_INV] = q.inv_acc > (q.inv_allow >> 1);
  end

  always_comb begin
    d = q;
    d.rst_cw_q = fault_reset_cw_i;
    d.tick_cnt = tick ? 32'h0 : q.tick_cnt + 32'h1;
    // cumulative counting: only oc_clear, or a reset edge at full count, clears the run
    if (meas_i.oc_event) begin
      if (q.oc_cnt < 3'(`DSST_OC_TRIP_CNT)) begin
        d.oc_cnt = q.oc_cnt + 3'h1;
      end
    end else if (meas_i.oc_clear || (reset_edge && q.oc_cnt == 3'(`DSST_OC_TRIP_CNT))) begin
      d.oc_cnt = 3'h0;
    end
    if (!src_active[`DSST_TRIP_CLIM]) begin
      d.clim_ms = 16'h0;
    end else if (tick && q.clim_ms < 16'(CLIM_MS)) begin
      d.clim_ms = q.clim_ms + 16'h1;
    end
    if (!src_active[`DSST_TRIP_STALL]) begin
      d.stall_ms = 32'h0;
    end else if (tick && q.stall_ms != 32'hffffffff) begin
      d.stall_ms = q.stall_ms + 32'h1;
    end
    // overload heats the accumulator, otherwise it cools back to zero
    if (tick) begin
      if (meas_i.overload) begin
        if (q.inv_acc != 32'hffffffff) begin
          d.inv_acc = q.inv_acc + 32'h1;
        end
      end else if (q.inv_acc != 32'h0) begin
        d.inv_acc = q.inv_acc - 32'h1;
      end
    end
    for (int i = 1; i <= 7; i++) begin
      if (trip_set[i]) begin
        d.trips[i] = 1'b1;
      end else if (reset_edge && !src_active[i]) begin
        d.trips[i] = 1'b0;
      end
    end
    d.warn = q.cfg[`DSST_CFG_WARN_EN_BIT] ? (warn_raw & ~d.trips) : 7'h0;
    d.code = dsst_code(d.trips);
    d.status = 16'h0;
    d.status[0] = seq_i.init_done & ~seq_i.config_mode;
    d.status[1] = (seq_state_i == DSST_SWITCHED_ON) ||
                  (seq_state_i == DSST_OP_ENABLED);
    d.status[2] = seq_state_i == DSST_OP_ENABLED;
    d.status[3] = |d.trips;
    d.status[4] = seq_i.line_present;
    d.status[5] = ~seq_i.quickstop_react;
    d.status[6] = seq_state_i == DSST_SW_ON_DISABLED;
    d.status[9] = seq_i.comms_ctrl_sel;
    d.status[12] = seq_i.jog_sel;
    d.status[13] = seq_i.reverse_sel;
    d.status[14] = seq_i.comms_ref_sel;
    d.status[15] = ~seq_i.enable_op_cmd | seq_i.quickstop_react;
    // bus: one wait state, ack dropped the cycle after it is given
    d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    d.rdata = 32'h0;
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      if (wb_adr_i == `DSST_ADR_STATUS) begin
        d.rdata = {16'h0, q.status};
      end else if (wb_adr_i == `DSST_ADR_CONFIG) begin
        d.rdata = {30'h0, q.cfg};
      end else if (wb_adr_i == `DSST_ADR_OV_LEVEL) begin
        d.rdata = {16'h0, q.ov_lvl};
      end else if (wb_adr_i == `DSST_ADR_BRAKE_LEVEL) begin
        d.rdata = {16'h0, q.brake_lvl};
      end else if (wb_adr_i == `DSST_ADR_UV_LEVEL) begin
        d.rdata = {16'h0, q.uv_lvl};
      end else if (wb_adr_i == `DSST_ADR_MIN_LEVEL) begin
        d.rdata = {16'h0, q.min_lvl};
      end else if (wb_adr_i == `DSST_ADR_STALL_TIME) begin
        d.rdata = {16'h0, q.stall_s};
      end else if (wb_adr_i == `DSST_ADR_INV_ALLOW) begin
        d.rdata = q.inv_allow;
      end else if (wb_adr_i == `DSST_ADR_TRIPS) begin
        d.rdata = {24'h0, q.trips, 1'b0};
      end else if (wb_adr_i == `DSST_ADR_WARNINGS) begin
        d.rdata = {24'h0, q.warn, 1'b0};
      end else if (wb_adr_i == `DSST_ADR_TRIP_CODE) begin
        d.rdata = {26'h0, q.code};
      end
      if (wb_we_i) begin
        if (wb_adr_i == `DSST_ADR_CONFIG) begin
          if (wb_sel_i[0]) begin
            d.cfg = wb_dat_i[1:0];
          end
        end else if (wb_adr_i == `DSST_ADR_OV_LEVEL) begin
          d.ov_lvl = dsst_wr16(q.ov_lvl, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `DSST_ADR_BRAKE_LEVEL) begin
          d.brake_lvl = dsst_wr16(q.brake_lvl, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `DSST_ADR_UV_LEVEL) begin
          d.uv_lvl = dsst_wr16(q.uv_lvl, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `DSST_ADR_MIN_LEVEL) begin
          d.min_lvl = dsst_wr16(q.min_lvl, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `DSST_ADR_STALL_TIME) begin
          d.stall_s = dsst_wr16(q.stall_s, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `DSST_ADR_INV_ALLOW) begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
              d.inv_allow[8*b +: 8] = wb_dat_i[8*b +: 8];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.cfg <= `DSST_CFG_RESET;
      q.ov_lvl <= `DSST_OV_LEVEL_RESET;
      q.brake_lvl <= `DSST_BRAKE_LEVEL_RESET;
      q.uv_lvl <= `DSST_UV_LEVEL_RESET;
      q.min_lvl <= `DSST_MIN_LEVEL_RESET;
      q.stall_s <= STALL_S_RESET;
      q.inv_allow <= `DSST_INV_ALLOW_RESET;
      q.status <= 16'h0020;
    end else begin
      q <= d;
    end
  end

  // combinational so that a fresh trip cuts the gates in its own cycle
  assign power_enable_o = run_request_i & ~|q.trips & ~|trip_set;
  assign status_word_o = q.status;
  assign trips_o = q.trips;
  assign warnings_o = q.warn;
  assign trip_code_o = q.code;
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_trip_cuts_power;
    (|trip_set) |-> !power_enable_o;
  endproperty
  a_trip_cuts_power: assert property (p_trip_cuts_power)
    else $error("power stage enabled during a trip");

  property p_latch_holds;
    q.trips[`DSST_TRIP_STACK_OC] && !reset_edge |=> q.trips[`DSST_TRIP_STACK_OC];
  endproperty
  a_latch_holds: assert property (p_latch_holds)
    else $error("trip latch dropped without a reset edge");

  property p_blocked;
    (|q.trips) |-> !power_enable_o;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("power stage enabled with a latched trip");

  property p_persist;
    reset_edge && meas_i.stack_oc |=> q.trips[`DSST_TRIP_STACK_OC];
  endproperty
  a_persist: assert property (p_persist)
    else $error("trip cleared while its cause persists");

  property p_code;
    q.trips[1] |-> q.code == 6'h01;
  endproperty
  a_code: assert property (p_code)
    else $error("trip code does not match lowest latched trip");

  property p_warn_off;
    !q.cfg[`DSST_CFG_WARN_EN_BIT] |=> warnings_o == 7'h0;
  endproperty
  a_warn_off: assert property (p_warn_off)
    else $error("warning shown while display disabled");

  property p_oc_five;
    meas_i.oc_event [*5] |=> q.trips[`DSST_TRIP_OC];
  endproperty
  a_oc_five: assert property (p_oc_five)
    else $error("five overcurrent events did not trip");

  property p_unused_zero;
    status_word_o[11:10] == 2'h0 && status_word_o[8:7] == 2'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused status bit set");

  property p_fault_bit;
    ##1 status_word_o[3] == |q.trips;
  endproperty
  a_fault_bit: assert property (p_fault_bit)
    else $error("faulted bit disagrees with latches");

  property p_stop_bit;
    !seq_i.enable_op_cmd |=> status_word_o[15];
  endproperty
  a_stop_bit: assert property (p_stop_bit)
    else $error("stopping bit clear after enable withdrawn");

  property p_reset_edge;
    $rose(fault_reset_cw_i) |-> reset_edge;
  endproperty
  a_reset_edge: assert property (p_reset_edge)
    else $error("rising reset bit not seen");
endmodule

/* verification/dsst_ctrl_model.sv */
// controller model: drives the fault-reset control bit as a clean 0 to 1 step
module dsst_ctrl_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // request from the bench
  input wire logic reset_req_i,
  // control word bit toward the block
  output logic fault_reset_cw_o
);
  logic [2:0] cnt_r;
  // low for a cycle first so the block always sees a rising step, then high for two cycles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 3'h0;
    end else if (reset_req_i && cnt_r == 3'h0) begin
      cnt_r <= 3'h4;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
  assign fault_reset_cw_o = (cnt_r == 3'h3) || (cnt_r == 3'h2);
endmodule

/* verification/test_drive_status_and_trip_logic.sv */
// self-checking bench for the drive status and trip block
`include "dsst_params.svh"
module test_drive_status_and_trip_logic import dsst_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, cyc, stb, we, ack, pe, rreq, frc, run;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd;
  logic [15:0] sw;
  logic [7:1] trips, warn;
  logic [5:0] code;
  dsst_seq_state_e st;
  dsst_seq_s sq;
  dsst_meas_s ms;
  int failures = 0;
  int n_tests = 0;
  logic [8:0] pat [3] = '{9'h155, 9'h0aa, 9'h1ff};

  dsst_top #(.TICK_CYCLES(10), .CLIM_MS(4)) i_dsst_top (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .seq_state_i(st), .seq_i(sq), .fault_reset_cw_i(frc), .run_request_i(run),
    .meas_i(ms), .power_enable_o(pe), .status_word_o(sw), .trips_o(trips),
    .warnings_o(warn), .trip_code_o(code));
  dsst_ctrl_model i_dsst_ctrl_model (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reset_req_i(rreq), .fault_reset_cw_o(frc));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // settle after the edge so registered outputs are read after they land
  task automatic ts(input int n);
    tick(n);
    #1;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    chk("wb ack", 32'h1, {31'h0, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic freset;
    tick(1);
    rreq <= 1'b1;
    tick(1);
    rreq <= 1'b0;
    ts(6);
  endtask
  task automatic dc(input logic [15:0] v);
    tick(1);
    ms.dc_link <= v;
    ts(3);
  endtask
  function automatic logic [15:0] exp_sw(dsst_seq_state_e s, dsst_seq_s q, logic f);
    logic [15:0] w;
    w = 16'h0000;
    w[0] = q.init_done & ~q.config_mode;
    w[1] = (s == DSST_SWITCHED_ON) || (s == DSST_OP_ENABLED);
    w[2] = s == DSST_OP_ENABLED;
    w[3] = f;
    w[4] = q.line_present;
    w[5] = ~q.quickstop_react;
    w[6] = s == DSST_SW_ON_DISABLED;
    w[9] = q.comms_ctrl_sel;
    w[12] = q.jog_sel;
    w[13] = q.reverse_sel;
    w[14] = q.comms_ref_sel;
    w[15] = ~q.enable_op_cmd | q.quickstop_react;
    return w;
  endfunction

  task automatic t_status;
    for (int i = 0; i < 24; i++) begin
      tick(1);
      st <= dsst_seq_state_e'(i[2:0]);
      sq <= pat[i / 8];
      ts(2);
      chk("status", {16'h0, exp_sw(st, sq, 1'b0)}, {16'h0, sw});
    end
    tick(1);
    st <= DSST_SWITCHED_ON;
    sq <= 9'h155;
  endtask
  task automatic t_stack;
    tick(1);
    ms.stack_oc <= 1'b1;
    #1;
    chk("power", 32'h0, {31'h0, pe});
    ts(2);
    chk("trips", 32'h2, {25'h0, trips});
    chk("code", 32'h2, {26'h0, code});
    chk("warn", 32'h0, {25'h0, warn});
    chk("faulted", 32'h1, {31'h0, sw[3]});
    tick(1);
    ms.stack_oc <= 1'b0;
    ts(4);
    chk("held", 32'h2, {25'h0, trips});
    chk("power", 32'h0, {31'h0, pe});
    freset;
    chk("cleared", 32'h0, {25'h0, trips});
    chk("code", 32'h0, {26'h0, code});
    chk("power", 32'h1, {31'h0, pe});
  endtask
  task automatic t_volt;
    wb(1'b0, `DSST_ADR_OV_LEVEL, 32'h0);
    chk("ov level", 32'h0000c800, rd);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    dc(16'hc1c0);
    chk("ov warn", 32'h1, {25'h0, warn});
    dc(16'hc1bf);
    chk("ov warn", 32'h0, {25'h0, warn});
    // raise the lowest level above the trip level so the midpoint warns before tripping
    wb(1'b1, `DSST_ADR_MIN_LEVEL, 32'h00006000);
    dc(16'h5ee0);
    chk("uv warn", 32'h4, {25'h0, warn});
    dc(16'h5ee1);
    chk("uv warn", 32'h0, {25'h0, warn});
    wb(1'b1, `DSST_ADR_CONFIG, 32'h0);
    dc(16'hc1c0);
    chk("warn off", 32'h0, {25'h0, warn});
    wb(1'b1, `DSST_ADR_CONFIG, 32'h1);
    tick(1);
    ms.stack_oc <= 1'b1;
    ms.dc_link <= 16'hc800;
    ts(3);
    chk("two trips", 32'h3, {25'h0, trips});
    chk("code", 32'h1, {26'h0, code});
    tick(1);
    ms.stack_oc <= 1'b0;
    freset;
    chk("ov kept", 32'h1, {25'h0, trips});
    dc(16'h8000);
    freset;
    chk("cleared", 32'h0, {25'h0, trips});
  endtask
  task automatic t_oc;
    for (int i = 1; i <= 5; i++) begin
      tick(1);
      ms.oc_event <= 1'b1;
      tick(1);
      ms.oc_event <= 1'b0;
      ts(2);
      if (i == 1) chk("oc warn", 32'h0, {25'h0, warn});
      if (i == 2) chk("oc warn", 32'h8, {25'h0, warn});
      if (i == 4) chk("oc early", 32'h0, {25'h0, trips});
    end
    chk("oc trip", 32'h8, {25'h0, trips});
    freset;
    chk("oc reset", 32'h0, {25'h0, trips});
  endtask
  task automatic t_clim;
    wb(1'b1, `DSST_ADR_CONFIG, 32'h3);
    tick(1);
    ms.over_200 <= 1'b1;
    ts(25);
    chk("clim early", 32'h0, {25'h0, trips});
    ts(25);
    chk("clim trip", 32'h10, {25'h0, trips});
    chk("clim warn", 32'h0, {25'h0, warn});
    tick(1);
    ms.over_200 <= 1'b0;
    wb(1'b1, `DSST_ADR_CONFIG, 32'h1);
    freset;
    chk("clim reset", 32'h0, {25'h0, trips});
  endtask
  task automatic t_inv;
    wb(1'b1, `DSST_ADR_INV_ALLOW, 32'h4);
    tick(1);
    ms.overload <= 1'b1;
    ts(15);
    chk("inv early warn", 32'h0, {25'h0, warn});
    ts(25);
    chk("inv warn", 32'h40, {25'h0, warn});
    chk("inv early trip", 32'h0, {25'h0, trips});
    ts(40);
    chk("inv trip", 32'h40, {25'h0, trips});
    tick(1);
    ms.overload <= 1'b0;
    wb(1'b1, `DSST_ADR_INV_ALLOW, `DSST_INV_ALLOW_RESET);
    freset;
    chk("inv reset", 32'h0, {25'h0, trips});
  endtask
  // a one-second stall time keeps the run to about ten thousand cycles
  task automatic t_stall;
    wb(1'b0, `DSST_ADR_STATUS, 32'h0);
    chk("status reg", {16'h0, exp_sw(st, sq, 1'b0)}, rd);
    wb(1'b1, `DSST_ADR_STALL_TIME, 32'h1);
    tick(1);
    ms.in_limit <= 1'b1;
    ms.rotating <= 1'b0;
    ts(4000);
    chk("stall early warn", 32'h0, {25'h0, warn});
    ts(2000);
    chk("stall warn", 32'h20, {25'h0, warn});
    chk("stall early trip", 32'h0, {25'h0, trips});
    ts(5000);
    chk("stall trip", 32'h20, {25'h0, trips});
    tick(1);
    ms.in_limit <= 1'b0;
    ms.rotating <= 1'b1;
    freset;
    chk("stall reset", 32'h0, {25'h0, trips});
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // the whole sequence needs about eleven thousand cycles, mostly the stall test
  initial begin
    #(40000 * 4);
    failures++;
    results();
  end
  initial begin
    rst_n_i = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    rreq = 1'b0;
    run = 1'b1;
    st = DSST_SWITCHED_ON;
    sq = 9'h155;
    ms = '0;
    ms.dc_link = 16'h8000;
    ms.rotating = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_status;
    t_stack;
    t_volt;
    t_oc;
    t_clim;
    t_inv;
    t_stall;
    results();
  end
endmodule
